//--- bench/rac_top_asserts.sv
// concurrent checks for the rac_top register bank, seeing its ports only.
// assumes one pclk domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rac_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic gain_adjusted,
   input wire logic filt_sample,
   input wire logic wake_deep_sleep_mode_a,
   input wire logic wake_deep_sleep_mode_b,
   input wire logic [1:0] deviation_hysteresis_sel,
   input wire logic dead_zone_symmetric,
   input wire logic [5:0] settle_samples,
   input wire logic accumulate_en,
   input wire logic [6:0] avg_len,
   input wire logic analog_gain_hold,
   input wire logic digital_gain_hold,
   input wire logic [1:0] synth_cal_config,
   input wire logic [1:0] pump_cal_stage_enable,
   input wire logic pump_cal_skip,
   input wire logic [3:0] pump_current_code
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // one wait-free access cycle per setup
   chk_ready_setup: assert property ($past(presetn) |-> pready == $past(psel && !penable))
      else $error("pready not one cycle after setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // stable code held two cycles, so either decode latency agrees
   chk_dead_zone: assert property ($past(presetn, 2) && $past(presetn)
      && $past(deviation_hysteresis_sel, 2) == deviation_hysteresis_sel
      && $past(deviation_hysteresis_sel) == deviation_hysteresis_sel
      |-> dead_zone_symmetric == (deviation_hysteresis_sel == 2'h0))
      else $error("dead zone symmetry wrong for hysteresis code");
   chk_settle_range: assert property ($past(presetn) |->
      settle_samples inside {6'h08, 6'h10, 6'h18, 6'h20})
      else $error("settle length not 8/16/24/32");
   chk_skip_start: assert property (gain_adjusted |=> !accumulate_en)
      else $error("accumulation not stopped after gain change");
   chk_skip_end: assert property ($rose(accumulate_en) |->
      $past(filt_sample) && !$past(gain_adjusted))
      else $error("accumulation resumed without a sample");
   chk_avg_range: assert property ($past(presetn) |->
      avg_len inside {7'h08, 7'h10, 7'h20, 7'h40})
      else $error("averaging length not 8/16/32/64");
   chk_hold_order: assert property (digital_gain_hold |-> analog_gain_hold)
      else $error("digital gain held while analog adjusts");
   chk_pump_skip: assert property ($past(presetn, 2) && $past(presetn)
      && $past(pump_cal_stage_enable, 2) == pump_cal_stage_enable
      && $past(pump_cal_stage_enable) == pump_cal_stage_enable
      |-> pump_cal_skip == (pump_cal_stage_enable == 2'h0))
      else $error("pump calibration skip wrong");
   chk_wake_cal: assert property (wake_deep_sleep_mode_a || wake_deep_sleep_mode_b |=>
      {synth_cal_config, pump_cal_stage_enable, pump_current_code} == 8'hA9)
      else $error("calibration register not reset on wake");

   cov_gain_adj: cover property (gain_adjusted ##1 !accumulate_en);
   cov_wake: cover property (wake_deep_sleep_mode_a || wake_deep_sleep_mode_b);
   cov_bad_addr: cover property (pslverr);
endmodule : rac_top_asserts

bind rac_top rac_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .gain_adjusted(gain_adjusted),
   .filt_sample(filt_sample), .wake_deep_sleep_mode_a(wake_deep_sleep_mode_a),
   .wake_deep_sleep_mode_b(wake_deep_sleep_mode_b), .avg_len(avg_len),
   .deviation_hysteresis_sel(deviation_hysteresis_sel), .settle_samples(settle_samples),
   .dead_zone_symmetric(dead_zone_symmetric), .accumulate_en(accumulate_en),
   .analog_gain_hold(analog_gain_hold), .digital_gain_hold(digital_gain_hold),
   .synth_cal_config(synth_cal_config), .pump_cal_stage_enable(pump_cal_stage_enable),
   .pump_cal_skip(pump_cal_skip), .pump_current_code(pump_current_code));
`default_nettype wire

//--- bench/rac_top_tb.sv
// self-checking bench for rac_top: apb register traffic and radio strobes.
// assumes rac_pkg is compiled first and the checker is bound alongside.
`timescale 1ns/1ps
`default_nettype none
module rac_top_tb
   import rac_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic dz, acc_en, a_hold, d_hold, pump_skip;
   logic [5:0] strb;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] hyst, lo_bias, cal_cfg, pump_en;
   logic [5:0] settle;
   logic [6:0] avg;
   logic [7:0] rx_bias;
   logic [2:0] tx_rsv;
   logic [3:0] pump_cur;
   logic [1:0] hold_exp [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
   int miscompares = 0;
   int n_compared = 0;

   rac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_found(strb[0]), .rx_restart(strb[1]),
      .gain_adjusted(strb[2]), .filt_sample(strb[3]), .wake_deep_sleep_mode_a(strb[4]),
      .wake_deep_sleep_mode_b(strb[5]), .deviation_hysteresis_sel(hyst),
      .dead_zone_symmetric(dz), .settle_samples(settle), .accumulate_en(acc_en),
      .avg_len(avg), .analog_gain_hold(a_hold), .digital_gain_hold(d_hold),
      .receive_front_end_bias(rx_bias), .tx_lo_buf_bias(lo_bias), .tx_reserved(tx_rsv),
      .synth_cal_config(cal_cfg), .pump_cal_stage_enable(pump_en),
      .pump_cal_skip(pump_skip), .pump_current_code(pump_cur));

   // 20 MHz clock
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // request held until pready is seen high at a rising edge; data taken there
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      // no fixed wait assumed; only the watchdog ends a stalled access
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
      apb(1'h0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk(er, 1'h0);
   endtask : rdchk

   // n edges, then settle to the next negedge
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : tick

   // one-cycle strobe on a radio status input
   task automatic pulse(input int b);
      @(posedge pclk);
      strb[b] <= 1'h1;
      @(posedge pclk);
      strb[b] <= 1'h0;
   endtask : pulse

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // hang guard, far beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      final_report();
   end

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
      strb = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      rdchk(RAC_IDX_GAIN_CFG0, 8'h91);
      rdchk(RAC_IDX_RX_BIAS, 8'h56);
      rdchk(RAC_IDX_TX_BIAS, 8'h10);
      rdchk(RAC_IDX_SYNTH_CAL3, 8'hA9);
      $display("test reset values done");
      // every code of every gain field at once
      for (int c = 0; c < 4; c++) begin
         apb(1'h1, RAC_IDX_GAIN_CFG0, {4{c[1:0]}});
         tick(2);
         chk(hyst, c);
         chk(dz, c == 0);
         chk(settle, (c + 1) * 8);
         chk(avg, 8 << c);
         chk({a_hold, d_hold}, hold_exp[c]);
         rdchk(RAC_IDX_GAIN_CFG0, {4{c[1:0]}});
      end
      apb(1'h1, RAC_IDX_GAIN_CFG0, 8'h04);
      pulse(0);
      tick(2);
      chk({a_hold, d_hold}, 2'h3);
      pulse(1);
      tick(2);
      chk({a_hold, d_hold}, 2'h0);
      $display("test gain codes and holds done");
      // shortest settle: seven samples keep it off, the eighth ends it
      apb(1'h1, RAC_IDX_GAIN_CFG0, 8'h00);
      tick(1);
      pulse(2);
      tick(0);
      chk(acc_en, 1'h0);
      @(posedge pclk);
      strb[3] <= 1'h1;
      repeat (7) @(posedge pclk);
      strb[3] <= 1'h0;
      tick(0);
      chk(acc_en, 1'h0);
      pulse(3);
      tick(1);
      chk(acc_en, 1'h1);
      $display("test settle count done");
      apb(1'h1, RAC_IDX_RX_BIAS, 8'hA5);
      rdchk(RAC_IDX_RX_BIAS, 8'hA5);
      chk(rx_bias, 8'hA5);
      // reserved low bits written as zero
      apb(1'h1, RAC_IDX_TX_BIAS, 8'hF8);
      rdchk(RAC_IDX_TX_BIAS, 8'h30);
      chk({lo_bias, tx_rsv}, 5'h18);
      $display("test bias registers done");
      apb(1'h1, RAC_IDX_SYNTH_CAL3, 8'h05);
      tick(2);
      chk(pump_skip, 1'h1);
      chk({cal_cfg, pump_en, pump_cur}, 8'h05);
      rdchk(RAC_IDX_SYNTH_CAL3, 8'h05);
      pulse(4);
      rdchk(RAC_IDX_SYNTH_CAL3, 8'hA9);
      apb(1'h1, RAC_IDX_SYNTH_CAL3, 8'h3C);
      tick(2);
      chk(pump_skip, 1'h0);
      pulse(5);
      rdchk(RAC_IDX_SYNTH_CAL3, 8'hA9);
      apb(1'h0, 16'hDF1D, 8'h00);
      chk(er, 1'h1);
      chk(rd, 32'h0);
      $display("test calibration and unmapped done");
      final_report();
   end
endmodule : rac_top_tb
`default_nettype wire

//--- pkg/rac_cfg_if.sv
// carries raw configuration codes out of the register bank and the
// decoded lengths and hold flags back into it.
// assumes one producer (bank) and one decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rac_cfg_if;
   import rac_pkg::*;
   rac_hyst_t hyst_code;
   logic [1:0] wait_code;
   rac_hold_t hold_code;
   logic [1:0] avg_code;
   logic [5:0] skip_len;
   logic [6:0] avg_len;
   logic hyst_symmetric;
   logic hold_analog_manual;
   logic hold_digital_manual;
   logic hold_sync_armed;

   modport bank (output hyst_code, wait_code, hold_code, avg_code,
      input skip_len, avg_len, hyst_symmetric, hold_analog_manual,
      hold_digital_manual, hold_sync_armed);
   modport dec (input hyst_code, wait_code, hold_code, avg_code,
      output skip_len, avg_len, hyst_symmetric, hold_analog_manual,
      hold_digital_manual, hold_sync_armed);
endinterface : rac_cfg_if
`default_nettype wire

//--- pkg/rac_pkg.sv
// register map, field layout, reset values and decode helpers for the
// radio gain-control / synthesizer-calibration register bank.
// assumes a 32-bit apb host addressing word-aligned registers.
package rac_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] RAC_IDX_GAIN_CFG0 = 16'hDF19;
   localparam logic [15:0] RAC_IDX_RX_BIAS = 16'hDF1A;
   localparam logic [15:0] RAC_IDX_TX_BIAS = 16'hDF1B;
   localparam logic [15:0] RAC_IDX_SYNTH_CAL3 = 16'hDF1C;
   localparam int RAC_ADDR_W = 18;

   // reset values
   localparam logic [7:0] RAC_RST_GAIN_CFG0 = 8'h91;
   localparam logic [7:0] RAC_RST_RX_BIAS = 8'h56;
   localparam logic [7:0] RAC_RST_TX_BIAS = 8'h10;
   localparam logic [7:0] RAC_RST_SYNTH_CAL3 = 8'hA9;

   // gain_control_config_0 fields (lsb positions, all two bits wide)
   localparam int RAC_HYST_LSB = 6;
   localparam int RAC_WAIT_LSB = 4;
   localparam int RAC_HOLD_LSB = 2;
   localparam int RAC_AVG_LSB = 0;
   // transmit_front_end_bias writable bits
   localparam logic [7:0] RAC_TX_BIAS_MASK = 8'h37;
   localparam int RAC_TX_LO_LSB = 4;
   // synth_calibration_3 fields
   localparam int RAC_SYN_CFG_LSB = 6;
   localparam int RAC_PUMP_EN_LSB = 4;
   localparam int RAC_PUMP_CUR_LSB = 0;

   // settling wait is (code+1)*step samples, averaging is base<<code
   localparam int RAC_SKIP_STEP = 8;
   localparam int RAC_AVG_BASE = 8;

   typedef enum logic [1:0] {
      RAC_HYST_NONE, RAC_HYST_LOW, RAC_HYST_MED, RAC_HYST_LARGE
   } rac_hyst_t;

   typedef enum logic [1:0] {
      RAC_HOLD_NORMAL, RAC_HOLD_ON_SYNC, RAC_HOLD_ANALOG, RAC_HOLD_ALL
   } rac_hold_t;

   // byte address of a register index
   function automatic logic [RAC_ADDR_W-1:0] rac_addr(input logic [15:0] idx);
      rac_addr = {idx, 2'b00};
   endfunction : rac_addr
endpackage : rac_pkg

//--- rtl/rac_decode.sv
// combinational decode of the gain-control codes into sample counts and
// hold flags. assumes codes come straight from registers.
`timescale 1ns/1ps
`default_nettype none
module rac_decode
   import rac_pkg::*;
(
   rac_cfg_if.dec cfg
);
   // settling wait: 8, 16, 24, 32 samples
   // wait code decode
   always_comb begin
      cfg.skip_len = 6'((32'(cfg.wait_code) + 1) * RAC_SKIP_STEP);
   end

   // averaging: 8, 16, 32, 64 samples
   // averaging length decode
   always_comb begin
      cfg.avg_len = 7'(RAC_AVG_BASE << cfg.avg_code);
   end

   // only code 00 has the symmetric dead zone; 01, 10 and 11 are asymmetric
   // hysteresis dead zone
   always_comb begin
      cfg.hyst_symmetric = (cfg.hyst_code == RAC_HYST_NONE);
   end

   // freeze policy decode
   always_comb begin
      cfg.hold_analog_manual = 1'b0;
      cfg.hold_digital_manual = 1'b0;
      cfg.hold_sync_armed = 1'b0;
      unique case (cfg.hold_code)
         RAC_HOLD_NORMAL: ;
         RAC_HOLD_ON_SYNC: cfg.hold_sync_armed = 1'b1;
         RAC_HOLD_ANALOG: cfg.hold_analog_manual = 1'b1;
         RAC_HOLD_ALL: begin
            cfg.hold_analog_manual = 1'b1;
            cfg.hold_digital_manual = 1'b1;
         end
      endcase
   end
endmodule : rac_decode
`default_nettype wire

//--- rtl/rac_top.sv
// apb register bank for the radio gain control, front-end bias and the
// synthesizer calibration register 3, plus the small amount of
// gain-control sequencing those settings steer.
// assumes apb master on pclk; radio status inputs synchronous to pclk.
// assumes the radio samples the settings outputs on pclk as well.
// registers sit at sparse word indices; byte address is four times it.
// outputs all come straight from flops, so the radio sees no glitches.
//
// What this block does
// - the hysteresis field picks none, low, medium or large hysteresis.
// - after a gain change, 8/16/24/32 filter samples are skipped first.
// - freeze code 00 lets the gain adjust whenever needed.
// - in sync-freeze mode the gain is held once a sync word is seen.
// - analog-only freeze holds analog gain, digital keeps adjusting.
// - full freeze holds analog and digital gain for manual override.
// - averaging length is 8, 16, 32 or 64 samples by code.
// - a zero pump calibration enable skips the pump calibration stage.
// - the low nibble of calibration register 3 sets the pump current.
// - calibration register 3 resets on return from deep sleep modes.
`timescale 1ns/1ps
`default_nettype none
module rac_top
   import rac_pkg::*;
#(
   parameter int ADDR_W = RAC_ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio status strobes, synchronous to pclk
   input wire logic sync_found,
   input wire logic rx_restart,
   input wire logic gain_adjusted,
   input wire logic filt_sample,
   input wire logic wake_deep_sleep_mode_a,
   input wire logic wake_deep_sleep_mode_b,
   // gain-control settings to the radio
   output logic [1:0] deviation_hysteresis_sel,
   output logic dead_zone_symmetric,
   output logic [5:0] settle_samples,
   output logic accumulate_en,
   output logic [6:0] avg_len,
   output logic analog_gain_hold,
   output logic digital_gain_hold,
   // front-end bias settings
   output logic [7:0] receive_front_end_bias,
   output logic [1:0] tx_lo_buf_bias,
   output logic [2:0] tx_reserved,
   // synthesizer calibration settings
   output logic [1:0] synth_cal_config,
   output logic [1:0] pump_cal_stage_enable,
   output logic pump_cal_skip,
   output logic [3:0] pump_current_code
);
   // register storage
   logic [7:0] gain_control_config_0_r;
   logic [7:0] receive_front_end_bias_r;
   logic [7:0] transmit_front_end_bias_r;
   logic [7:0] synth_calibration_3_r;

   // bus pipeline
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata_nxt;
   logic hit_nxt;
   logic setup;
   logic wr_en;

   // register select and per-register write strobes
   logic [3:0] reg_sel;
   logic wr_gain_cfg0;
   logic wr_rx_bias;
   logic wr_tx_bias;
   logic wr_cal3;

   // settling skip after a gain change
   logic [5:0] skip_cnt_r;
   logic accumulate_en_r;

   // gain hold flags
   logic sync_hold_r;
   logic analog_hold_r;
   logic digital_hold_r;

   // decoded settings, registered
   logic dead_zone_sym_r;
   logic [5:0] settle_r;
   logic [6:0] avg_len_r;

   // calibration bypass and deep-sleep wake
   logic pump_skip_r;
   logic wake_deep;

   // codes out to the decoder, lengths and flags back
   rac_cfg_if cfg ();

   // codes handed to the decoder
   // the enum casts keep the decoder's case items typed
   always_comb begin
      cfg.hyst_code = rac_hyst_t'(gain_control_config_0_r[RAC_HYST_LSB +: 2]);
      cfg.wait_code = gain_control_config_0_r[RAC_WAIT_LSB +: 2];
      cfg.hold_code = rac_hold_t'(gain_control_config_0_r[RAC_HOLD_LSB +: 2]);
      cfg.avg_code = gain_control_config_0_r[RAC_AVG_LSB +: 2];
   end

   // purely combinational, so the decoded values follow the register;
   // its outputs are registered below before they leave the block
   rac_decode u_decode (
      .cfg(cfg)
   );

   // setup phase of an apb transfer
   // pready and pslverr are prepared here and stand one cycle
   assign setup = psel & ~penable;

   // the access edge: pready was raised by this block one cycle earlier;
   // a write to an unmapped word is refused along with its pslverr
   assign wr_en = psel & penable & pwrite & pready_r & ~pslverr_r;

   // one-hot register select for a bus address; all zero when unmapped
   // the map is sparse, so whole byte addresses are compared
   function automatic logic [3:0] reg_select(input logic [ADDR_W-1:0] addr);
      reg_select = 4'h0;
      if (addr == rac_addr(RAC_IDX_GAIN_CFG0)) begin
         reg_select[0] = 1'b1;
      end
      if (addr == rac_addr(RAC_IDX_RX_BIAS)) begin
         reg_select[1] = 1'b1;
      end
      if (addr == rac_addr(RAC_IDX_TX_BIAS)) begin
         reg_select[2] = 1'b1;
      end
      if (addr == rac_addr(RAC_IDX_SYNTH_CAL3)) begin
         reg_select[3] = 1'b1;
      end
   endfunction : reg_select

   // decoded once, so the read mux and the write strobes agree on the map
   assign reg_sel = reg_select(paddr);
   assign wr_gain_cfg0 = wr_en & reg_sel[0];
   assign wr_rx_bias = wr_en & reg_sel[1];
   assign wr_tx_bias = wr_en & reg_sel[2];
   assign wr_cal3 = wr_en & reg_sel[3];

   // address decode and read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      hit_nxt = 1'b1;
      if (reg_sel[0]) begin
         rdata_nxt[7:0] = gain_control_config_0_r;
      end else if (reg_sel[1]) begin
         rdata_nxt[7:0] = receive_front_end_bias_r;
      end else if (reg_sel[2]) begin
         // unused bits 7:6 and 3 read as zero
         rdata_nxt[7:0] = transmit_front_end_bias_r & RAC_TX_BIAS_MASK;
      end else if (reg_sel[3]) begin
         rdata_nxt[7:0] = synth_calibration_3_r;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   // no wait state: answer is prepared in setup, presented in access
   // read data is zero outside its access cycle, so no stale byte shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~hit_nxt;
         prdata_r <= (setup & ~pwrite) ? rdata_nxt : 32'h0000_0000;
      end
   end

   // gain-control configuration register
   // all four fields are plain read/write; rac_decode interprets them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_control_config_0_r <= RAC_RST_GAIN_CFG0;
      end else if (wr_gain_cfg0) begin
         gain_control_config_0_r <= pwdata[7:0];
      end
   end

   // receive front-end bias currents, stored only
   // the analog effect of each current code belongs to the radio
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_front_end_bias_r <= RAC_RST_RX_BIAS;
      end else if (wr_rx_bias) begin
         receive_front_end_bias_r <= pwdata[7:0];
      end
   end

   // transmit bias; the reserved low bits are stored as written since
   // software is expected to keep them at zero
   // bits 7:6 and 3 are not stored, so they always read back as zero
   // reserved bits kept as written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_front_end_bias_r <= RAC_RST_TX_BIAS;
      end else if (wr_tx_bias) begin
         transmit_front_end_bias_r <= pwdata[7:0] & RAC_TX_BIAS_MASK;
      end
   end

   // leaving either deep sleep mode wipes the calibration state
   // a one-cycle pulse on either wake input is enough
   assign wake_deep = wake_deep_sleep_mode_a | wake_deep_sleep_mode_b;

   // software saves this word after a calibration and writes it back
   // before each hop instead of recalibrating
   // calibration register 3; a wake beats a same-cycle write, because
   // the register content is not retained through deep sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synth_calibration_3_r <= RAC_RST_SYNTH_CAL3;
      end else if (wake_deep) begin
         synth_calibration_3_r <= RAC_RST_SYNTH_CAL3;
      end else if (wr_cal3) begin
         synth_calibration_3_r <= pwdata[7:0];
      end
   end

   // sync-triggered hold: set by a sync word while armed, released by a
   // new receive start or when the policy leaves sync mode; a sync word
   // in the restart cycle wins so no detection is lost
   // limitation: a sync word seen while unarmed is not remembered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_hold_r <= 1'b0;
      end else if (!cfg.hold_sync_armed) begin
         sync_hold_r <= 1'b0;
      end else if (sync_found) begin
         sync_hold_r <= 1'b1;
      end else if (rx_restart) begin
         sync_hold_r <= 1'b0;
      end
   end

   // hold flags presented to the gain loop
   // one register stage, so a policy write never glitches the radio
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_hold_r <= 1'b0;
         digital_hold_r <= 1'b0;
      end else begin
         analog_hold_r <= cfg.hold_analog_manual | sync_hold_r;
         digital_hold_r <= cfg.hold_digital_manual | sync_hold_r;
      end
   end

   // settling skip after each gain change; a change seen while still
   // skipping restarts the count, so accumulation never mixes gains
   // samples outside a settling window are ignored; the count rests at zero
   // accumulate_en rests high after reset, with no settle window open
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_cnt_r <= 6'h00;
         accumulate_en_r <= 1'b1;
      end else if (gain_adjusted) begin
         skip_cnt_r <= cfg.skip_len;
         accumulate_en_r <= 1'b0;
      end else if (filt_sample && skip_cnt_r != 6'h00) begin
         skip_cnt_r <= skip_cnt_r - 6'h01;
         accumulate_en_r <= (skip_cnt_r == 6'h01);
      end
   end

   // decoded lengths and dead zone, registered for the radio
   // a code change reaches these outputs one edge after the write lands
   // zero in reset, then valid from the first edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_r <= 6'h00;
         avg_len_r <= 7'h00;
         dead_zone_sym_r <= 1'b0;
      end else begin
         settle_r <= cfg.skip_len;
         avg_len_r <= cfg.avg_len;
         dead_zone_sym_r <= cfg.hyst_symmetric;
      end
   end

   // charge-pump calibration stage bypass
   // derived here so the synthesizer need not decode the two-bit field
   // zero in reset; the reset enable code does not skip the stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_skip_r <= 1'b0;
      end else begin
         pump_skip_r <= (synth_calibration_3_r[RAC_PUMP_EN_LSB +: 2] == 2'h0);
      end
   end

   // bus outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // configuration straight from the register flops
   // hysteresis select out
   assign deviation_hysteresis_sel = gain_control_config_0_r[RAC_HYST_LSB +: 2];
   // gain-control settings
   assign dead_zone_symmetric = dead_zone_sym_r;
   assign settle_samples = settle_r;
   assign accumulate_en = accumulate_en_r;
   assign avg_len = avg_len_r;
   assign analog_gain_hold = analog_hold_r;
   assign digital_gain_hold = digital_hold_r;
   // front-end bias fields
   assign receive_front_end_bias = receive_front_end_bias_r;
   assign tx_lo_buf_bias = transmit_front_end_bias_r[RAC_TX_LO_LSB +: 2];
   assign tx_reserved = transmit_front_end_bias_r[2:0];
   // calibration register fields
   assign synth_cal_config = synth_calibration_3_r[RAC_SYN_CFG_LSB +: 2];
   assign pump_cal_stage_enable = synth_calibration_3_r[RAC_PUMP_EN_LSB +: 2];
   assign pump_cal_skip = pump_skip_r;
   assign pump_current_code = synth_calibration_3_r[RAC_PUMP_CUR_LSB +: 4];
endmodule : rac_top
`default_nettype wire
